// File: reset_recorder_pkg.sv
// shared constants and carrier types of the reset source recorder
package reset_recorder_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int POWERON_HOLD_TIME_US = 200;
  localparam int POWERON_HOLD_CYCLES = (POWERON_HOLD_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int WATCHDOG_HOLD_CYCLES = 16;
  localparam int BROWNOUT_STABLE_TIME_US = 100;
  localparam int BROWNOUT_STABLE_CYCLES = (BROWNOUT_STABLE_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int DEEP_STANDBY_WAKE_WAIT_CYCLES = 35;
  localparam int SOFT_RESET_HOLD_CYCLES = 32;
  localparam int BATTERY_HOLD_CYCLES = 16;
  localparam int CNT_W = 16;

  // ****************************************
  // status field positions
  // ****************************************
  localparam int ST0_POWERON_CAUSE_FLAG_BIT = 0;
  localparam int ST0_BROWN0_BIT = 1;
  localparam int ST0_DPS_BIT = 4;
  localparam int ST1_INDEPENDENT_WATCHDOG_BIT = 0;
  localparam int ST1_WWDT_BIT = 1;
  localparam int ST1_SW_BIT = 2;
  localparam int ST1_BATT_BIT = 3;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // brownout threshold levels, three selectable
  typedef enum logic [1:0] {LVL_LOW, LVL_MID, LVL_HIGH} brownLevel_t;

  typedef struct packed {
    logic [2:0] levelLow;
    logic [2:0] levelMid;
    logic [2:0] levelHigh;
  } brownCompare_t;

  typedef struct packed {
    logic [2:0] enable;
    logic [2:0] resetMode;
    brownLevel_t [2:0] level;
  } brownConfig_t;

  typedef struct packed {
    logic [7:0] status0;
    logic [7:0] status1;
    logic coldWarmStart;
  } resetStatus_t;

endpackage

// File: reset_hold_timer.sv
// counts out the release delay of one reset source
`timescale 1ns/1ps
`default_nettype none
module reset_hold_timer
  import reset_recorder_pkg::*;
#(
  parameter logic [CNT_W-1:0] HOLD = CNT_W'(WATCHDOG_HOLD_CYCLES)
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic trigger,
  output logic holding
);
  logic [CNT_W-1:0] countReg;

  // trigger level keeps restarting the count; release after HOLD quiet cycles
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      countReg <= '0;
      holding <= 1'b0;
    end else if (trigger) begin
      countReg <= HOLD;
      holding <= 1'b1;
    end else if (countReg > 16'h0001) begin
      countReg <= countReg - 16'h0001;
    end else begin
      countReg <= '0;
      holding <= 1'b0;
    end
  end

  a_hold_length: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(trigger) |-> holding [*2])
    else $error("hold released too early");
endmodule // reset_hold_timer
`default_nettype wire

// File: brownout_monitor.sv
// one brownout monitor: threshold select, interrupt or reset, stabilization
`timescale 1ns/1ps
`default_nettype none
module brownout_monitor
  import reset_recorder_pkg::*;
#(
  parameter int STABLE = BROWNOUT_STABLE_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic resetMode,
  input wire brownLevel_t level,
  input wire logic belowLow,
  input wire logic belowMid,
  input wire logic belowHigh,
  output logic irqPulse,
  output logic resetHold
);
  logic below;
  logic belowReg;

  always_comb begin
    case (level)
      LVL_LOW: below = belowLow;
      LVL_MID: below = belowMid;
      LVL_HIGH: below = belowHigh;
      default: below = belowLow;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      belowReg <= 1'b0;
      irqPulse <= 1'b0;
    end else begin
      belowReg <= below & enable;
      irqPulse <= below & enable & ~belowReg & ~resetMode;
    end
  end

  reset_hold_timer #(.HOLD(CNT_W'(STABLE))) stableTimer (
    .clk(clk),
    .rst_n(rst_n),
    .trigger(below & enable & resetMode),
    .holding(resetHold)
  );
endmodule // brownout_monitor
`default_nettype wire

// File: reset_source_recorder.sv
// reset source merge, release timing and cause recording
`timescale 1ns/1ps
`default_nettype none
module reset_source_recorder
  import reset_recorder_pkg::*;
#(
  parameter int POWERON_HOLD = POWERON_HOLD_CYCLES,
  parameter int BROWNOUT_STABLE = BROWNOUT_STABLE_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic supplyBelowPoweron,
  input wire logic external_reset_pin_n,
  input wire logic indepWatchdogUnderflow,
  input wire logic indepWatchdogResetMode,
  input wire logic windowedWatchdogOverflow,
  input wire logic windowedWatchdogResetMode,
  input wire brownCompare_t brownCompare,
  input wire brownConfig_t option_setting_word_1,
  input wire logic optionLoad,
  input wire logic deepStandbyWakeIrq,
  input wire logic deepStandbyActive,
  input wire logic sys_reset_request_bit,
  input wire logic batterySwitch,
  input wire logic batteryResetEnable,
  input wire logic coldWarmWrite,
  input wire logic coldWarmWriteData,
  output logic chipReset_n,
  output logic nmiPulse,
  output logic [2:0] brownIrq,
  output logic clockRestart,
  output resetStatus_t statusOut
);

  // ****************************************
  // power-on hold
  // ****************************************
  logic [CNT_W-1:0] porCountReg;
  logic porActive;
  logic porDoneReg;

  // rst_n is the root supply reset; counting starts once rst_n is released and supplyBelowPoweron is low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      porCountReg <= '0;
      porDoneReg <= 1'b0;
    end else if (supplyBelowPoweron) begin
      porCountReg <= '0;
      porDoneReg <= 1'b0;
    end else if (porCountReg >= CNT_W'(POWERON_HOLD - 1)) begin
      porDoneReg <= 1'b1;
    end else begin
      porCountReg <= porCountReg + 16'h0001;
    end
  end
  assign porActive = ~porDoneReg;

  // ****************************************
  // watchdogs, battery switch, software request
  // ****************************************
  logic iwdtReset, wwdtReset, battReset, swReset, iwdtHold, wwdtHold, battHold, swHold;
  logic swReqReg, swHoldReg;
  logic pinHoldReg;
  assign iwdtReset = indepWatchdogUnderflow & indepWatchdogResetMode;
  assign wwdtReset = windowedWatchdogOverflow & windowedWatchdogResetMode;
  assign battReset = batterySwitch & batteryResetEnable;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nmiPulse <= 1'b0;
    end else begin
      nmiPulse <= (indepWatchdogUnderflow & ~indepWatchdogResetMode)
        | (windowedWatchdogOverflow & ~windowedWatchdogResetMode);
    end
  end

  // request is edge-taken so a stuck request bit cannot lock the chip in reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      swReqReg <= 1'b0;
    end else begin
      swReqReg <= sys_reset_request_bit;
    end
  end
  assign swReset = sys_reset_request_bit & ~swReqReg;

  reset_hold_timer #(.HOLD(CNT_W'(WATCHDOG_HOLD_CYCLES))) iwdtTimer (
    .clk(clk), .rst_n(rst_n), .trigger(iwdtReset), .holding(iwdtHold)
  );
  reset_hold_timer #(.HOLD(CNT_W'(WATCHDOG_HOLD_CYCLES))) wwdtTimer (
    .clk(clk), .rst_n(rst_n), .trigger(wwdtReset), .holding(wwdtHold)
  );
  reset_hold_timer #(.HOLD(CNT_W'(SOFT_RESET_HOLD_CYCLES))) swTimer (
    .clk(clk), .rst_n(rst_n), .trigger(swReset), .holding(swHold)
  );
  reset_hold_timer #(.HOLD(CNT_W'(BATTERY_HOLD_CYCLES))) battTimer (
    .clk(clk), .rst_n(rst_n), .trigger(battReset), .holding(battHold)
  );

  // ****************************************
  // brownout monitors
  // ****************************************
  brownConfig_t brownCfgReg;
  logic [2:0] brownHold;
  logic [2:0] brownIrqRaw;
  logic [2:0] brownTrig;

  // option word only takes effect once loaded after power-on
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      brownCfgReg <= '0;
    end else if (porActive) begin
      brownCfgReg <= '0;
    end else if (optionLoad) begin
      brownCfgReg <= option_setting_word_1;
    end
  end

  for (genvar i = 0; i < 3; i++) begin : g_brown
    brownout_monitor #(.STABLE(BROWNOUT_STABLE)) monitor (
      .clk(clk),
      .rst_n(rst_n),
      .enable(brownCfgReg.enable[i]),
      .resetMode(brownCfgReg.resetMode[i]),
      .level(brownCfgReg.level[i]),
      .belowLow(brownCompare.levelLow[i]),
      .belowMid(brownCompare.levelMid[i]),
      .belowHigh(brownCompare.levelHigh[i]),
      .irqPulse(brownIrqRaw[i]),
      .resetHold(brownHold[i])
    );
  end
  assign brownTrig = brownHold;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      brownIrq <= 3'h0;
    end else begin
      brownIrq <= brownIrqRaw;
    end
  end

  // ****************************************
  // deep standby wake
  // ****************************************
  logic [5:0] dpsCountReg;
  logic dpsHoldReg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dpsCountReg <= '0;
      dpsHoldReg <= 1'b0;
      clockRestart <= 1'b0;
    end else if (deepStandbyActive & deepStandbyWakeIrq) begin
      dpsCountReg <= 6'(DEEP_STANDBY_WAKE_WAIT_CYCLES - 1);
      dpsHoldReg <= 1'b1;
      clockRestart <= 1'b1;
    end else if (dpsCountReg != 6'h00) begin
      dpsCountReg <= dpsCountReg - 6'h01;
      clockRestart <= 1'b0;
    end else begin
      dpsHoldReg <= 1'b0;
      clockRestart <= 1'b0;
    end
  end

  // ****************************************
  // merged reset
  // ****************************************
  logic anyReset;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pinHoldReg <= 1'b0;
    end else begin
      pinHoldReg <= ~external_reset_pin_n;
    end
  end
  assign swHoldReg = swHold;
  assign anyReset = porActive | pinHoldReg | iwdtHold | wwdtHold | swHoldReg | battHold
    | dpsHoldReg | (|brownTrig);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chipReset_n <= 1'b0;
    end else begin
      chipReset_n <= ~(anyReset | ~external_reset_pin_n);
    end
  end

  // ****************************************
  // cause recording
  // ****************************************
  logic [7:0] status0Reg, status1Reg;
  logic coldWarmReg;

  // flags survive every reset except power-on, but a pin reset clears the power-on flag; software reads them afterward
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status0Reg <= STATUS_RESET;
    end else if (porActive) begin
      status0Reg <= STATUS_RESET;
      status0Reg[ST0_POWERON_CAUSE_FLAG_BIT] <= 1'b1;
    end else begin
      if (~external_reset_pin_n) begin
        status0Reg[ST0_POWERON_CAUSE_FLAG_BIT] <= 1'b0;
      end
      for (int i = 0; i < 3; i++) begin
        if (brownTrig[i]) begin
          status0Reg[ST0_BROWN0_BIT + i] <= 1'b1;
        end
      end
      if (dpsHoldReg) begin
        status0Reg[ST0_DPS_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status1Reg <= STATUS_RESET;
    end else if (porActive) begin
      status1Reg <= STATUS_RESET;
    end else begin
      if (iwdtReset) status1Reg[ST1_INDEPENDENT_WATCHDOG_BIT] <= 1'b1;
      if (wwdtReset) status1Reg[ST1_WWDT_BIT] <= 1'b1;
      if (swReset) status1Reg[ST1_SW_BIT] <= 1'b1;
      if (battReset) status1Reg[ST1_BATT_BIT] <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      coldWarmReg <= 1'b0;
    end else if (porActive) begin
      coldWarmReg <= 1'b0;
    end else if (coldWarmWrite & coldWarmWriteData) begin
      coldWarmReg <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      statusOut <= '0;
    end else begin
      statusOut.status0 <= status0Reg;
      statusOut.status1 <= status1Reg;
      statusOut.coldWarmStart <= coldWarmReg;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_por_holds_reset: assert property (@(posedge clk) disable iff (!rst_n)
    supplyBelowPoweron |=> ##1 !chipReset_n)
    else $error("reset released while supply low");
  a_por_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
    porActive |=> status0Reg[ST0_POWERON_CAUSE_FLAG_BIT])
    else $error("power-on flag not set");
  a_pin_clears_por: assert property (@(posedge clk) disable iff (!rst_n)
    (!external_reset_pin_n && !porActive) |=> !status0Reg[ST0_POWERON_CAUSE_FLAG_BIT])
    else $error("pin reset left power-on flag");
  a_independent_watchdog_flag: assert property (@(posedge clk) disable iff (!rst_n)
    (iwdtReset && !porActive) |=> status1Reg[ST1_INDEPENDENT_WATCHDOG_BIT] ##1 !chipReset_n)
    else $error("independent watchdog reset not recorded");
  a_wdt_nmi_only: assert property (@(posedge clk) disable iff (!rst_n)
    (indepWatchdogUnderflow && !indepWatchdogResetMode) |=> nmiPulse)
    else $error("watchdog nmi missing");
  a_dps_wait: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(dpsHoldReg) |-> dpsHoldReg [*8] ##[27:28] !dpsHoldReg)
    else $error("deep standby wait wrong");
  a_sw_reset_flag: assert property (@(posedge clk) disable iff (!rst_n)
    (swReset && !porActive) |=> status1Reg[ST1_SW_BIT])
    else $error("software reset not recorded");
  a_cold_warm_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (coldWarmReg && !porActive) |=> coldWarmReg)
    else $error("cold/warm flag cleared without power-on");
  a_lvd_off_por: assert property (@(posedge clk) disable iff (!rst_n)
    porActive |=> brownCfgReg.enable == 3'h0)
    else $error("voltage detect enabled during power-on");
endmodule // reset_source_recorder
`default_nettype wire

// File: reset_source_model.sv
// far-side model: supply, reset pin, brownout comparators and software request
`timescale 1ns/1ps
`default_nettype none
module reset_source_model
  import reset_recorder_pkg::*;
(
  input wire logic clk,
  output var logic supplyBelowPoweron,
  output var logic external_reset_pin_n,
  output var brownCompare_t brownCompare,
  output var logic sys_reset_request_bit
);
  initial begin
    // supply starts under the threshold, as at power-up
    supplyBelowPoweron = 1'b1;
    external_reset_pin_n = 1'b1;
    brownCompare = '0;
    sys_reset_request_bit = 1'b0;
  end

  task automatic supply(input logic below);
    supplyBelowPoweron = below;
  endtask

  task automatic pinLow(input int n);
    external_reset_pin_n = 1'b0;
    repeat (n) @(posedge clk);
    #1;
    // pin has a pull-up, so release means high
    external_reset_pin_n = 1'b1;
  endtask

  task automatic brown(input brownCompare_t c);
    brownCompare = c;
  endtask

  task automatic softReset();
    sys_reset_request_bit = 1'b1;
    // held a few cycles: only the rising edge may count
    repeat (4) @(posedge clk);
    #1;
    sys_reset_request_bit = 1'b0;
  endtask
endmodule // reset_source_model
`default_nettype wire

// File: reset_source_recorder_tb_top.sv
// self-checking testbench of the reset source recorder
`timescale 1ns/1ps
`default_nettype none
module reset_source_recorder_tb_top
  import reset_recorder_pkg::*;
;
  localparam int PH = 20;
  logic clk, rst_n;
  logic supplyBelowPoweron, external_reset_pin_n, sys_reset_request_bit;
  brownCompare_t brownCompare;
  brownConfig_t option_setting_word_1;
  logic indepUnder, indepMode, windUnder, windMode, optionLoad;
  logic wakeIrq, standbyActive, battSwitch, battEnable, cwWrite, cwData;
  logic chipReset_n, nmiPulse, clockRestart;
  logic [2:0] brownIrq;
  resetStatus_t statusOut;
  logic [4:0] seen;
  logic seenClr;
  int nFail = 0;
  int totalChecks = 0;

  reset_source_recorder #(.POWERON_HOLD(PH), .BROWNOUT_STABLE(BROWNOUT_STABLE_CYCLES))
    reset_source_recorder_i (
    .clk(clk), .rst_n(rst_n), .supplyBelowPoweron(supplyBelowPoweron),
    .external_reset_pin_n(external_reset_pin_n), .indepWatchdogUnderflow(indepUnder),
    .indepWatchdogResetMode(indepMode), .windowedWatchdogOverflow(windUnder),
    .windowedWatchdogResetMode(windMode), .brownCompare(brownCompare),
    .option_setting_word_1(option_setting_word_1), .optionLoad(optionLoad),
    .deepStandbyWakeIrq(wakeIrq), .deepStandbyActive(standbyActive),
    .sys_reset_request_bit(sys_reset_request_bit), .batterySwitch(battSwitch),
    .batteryResetEnable(battEnable), .coldWarmWrite(cwWrite), .coldWarmWriteData(cwData),
    .chipReset_n(chipReset_n), .nmiPulse(nmiPulse), .brownIrq(brownIrq),
    .clockRestart(clockRestart), .statusOut(statusOut));

  reset_source_model reset_source_model_i (
    .clk(clk), .supplyBelowPoweron(supplyBelowPoweron),
    .external_reset_pin_n(external_reset_pin_n), .brownCompare(brownCompare),
    .sys_reset_request_bit(sys_reset_request_bit));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // one-cycle pulses are kept sticky so a check never misses them
  always @(posedge clk) seen <= seenClr ? 5'h00 : (seen | {clockRestart, brownIrq, nmiPulse});

  // ****************************************
  // tasks
  // ****************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // clear goes through the sampling process so seen keeps a single writer
  task automatic clearSeen();
    seenClr = 1'b1;
    cyc(1);
    seenClr = 1'b0;
  endtask

  task automatic results();
    $display("checks %0d, mismatches %0d", totalChecks, nFail);
    if (nFail == 0 && totalChecks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    totalChecks++;
    if (got !== exp) begin
      nFail++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // waits for reset to be low, then measures how long it stays low
  task automatic lowSpan(input int bound, input int lo, input int hi);
    int k;
    int n;
    k = 0;
    n = 0;
    while (chipReset_n !== 1'b0 && k < 8) begin
      cyc(1);
      k++;
    end
    while (chipReset_n === 1'b0 && n < bound) begin
      cyc(1);
      n++;
    end
    if (k == 8 || n == bound) begin
      nFail++;
      results();
    end else begin
      chk(16'(n), (n >= lo && n <= hi) ? 16'(n) : 16'(lo));
    end
  endtask

  task automatic coldWrite(input logic d);
    cwData = d;
    cwWrite = 1'b1;
    cyc(1);
    cwWrite = 1'b0;
    cyc(2);
  endtask

  task automatic dogPulse(input int which, input logic mode);
    indepMode = mode;
    windMode = mode;
    indepUnder = (which == 0);
    windUnder = (which == 1);
    cyc(1);
    indepUnder = 1'b0;
    windUnder = 1'b0;
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rst_n = 1'b0;
    {indepUnder, indepMode, windUnder, windMode, optionLoad} = '0;
    {wakeIrq, standbyActive, battSwitch, battEnable, cwWrite, cwData} = '0;
    option_setting_word_1 = '0;
    seenClr = 1'b1;
    cyc(8);
    rst_n = 1'b1;
    cyc(30);
    chk(16'(chipReset_n), 16'h0000);
    reset_source_model_i.supply(1'b0);
    lowSpan(40, PH, PH + 2);
    chk(16'(statusOut.status0), 16'h0001 << ST0_POWERON_CAUSE_FLAG_BIT);
    chk(16'(statusOut.coldWarmStart), 16'h0000);
    coldWrite(1'b0);
    chk(16'(statusOut.coldWarmStart), 16'h0000);
    coldWrite(1'b1);
    chk(16'(statusOut.coldWarmStart), 16'h0001);
    for (int i = 0; i < 2; i++) begin
      clearSeen();
      dogPulse(i, 1'b0);
      cyc(4);
      chk(16'(seen[0]), 16'h0001);
      chk(16'(chipReset_n), 16'h0001);
      chk(16'(statusOut.status1), 16'(i));
      dogPulse(i, 1'b1);
      lowSpan(40, WATCHDOG_HOLD_CYCLES, WATCHDOG_HOLD_CYCLES + 2);
    end
    chk(16'(statusOut.status1), 16'h0003);
    fork
      reset_source_model_i.softReset();
    join_none
    lowSpan(60, SOFT_RESET_HOLD_CYCLES, SOFT_RESET_HOLD_CYCLES + 2);
    cyc(6);
    chk(16'(chipReset_n), 16'h0001);
    chk(16'(statusOut.status1), 16'h0007);
    clearSeen();
    standbyActive = 1'b1;
    wakeIrq = 1'b1;
    cyc(1);
    wakeIrq = 1'b0;
    lowSpan(60, 34, 35);
    standbyActive = 1'b0;
    chk(16'(seen[4]), 16'h0001);
    chk(16'(statusOut.status0), 16'h0011);
    battEnable = 1'b1;
    battSwitch = 1'b1;
    cyc(1);
    battSwitch = 1'b0;
    lowSpan(40, BATTERY_HOLD_CYCLES, BATTERY_HOLD_CYCLES + 2);
    chk(16'(statusOut.status1), 16'h000F);
    clearSeen();
    reset_source_model_i.brown('{3'h7, 3'h7, 3'h7});
    cyc(10);
    chk(16'(seen), 16'h0000);
    chk(16'(chipReset_n), 16'h0001);
    reset_source_model_i.brown('0);
    option_setting_word_1 = '{3'h7, 3'h2, '{LVL_HIGH, LVL_MID, LVL_LOW}};
    optionLoad = 1'b1;
    cyc(1);
    optionLoad = 1'b0;
    cyc(2);
    reset_source_model_i.brown('{3'h1, 3'h1, 3'h3});
    cyc(6);
    chk(16'(seen[3:1]), 16'h0001);
    chk(16'(chipReset_n), 16'h0001);
    reset_source_model_i.brown('{3'h1, 3'h1, 3'h7});
    cyc(6);
    chk(16'(seen[3:1]), 16'h0005);
    reset_source_model_i.brown('{3'h1, 3'h3, 3'h7});
    cyc(50);
    chk(16'(chipReset_n), 16'h0000);
    reset_source_model_i.brown('0);
    lowSpan(4100, BROWNOUT_STABLE_CYCLES, BROWNOUT_STABLE_CYCLES + 3);
    chk(16'(statusOut.status0), 16'h0015);
    fork
      reset_source_model_i.pinLow(6);
    join_none
    cyc(4);
    chk(16'(chipReset_n), 16'h0000);
    lowSpan(20, 1, 6);
    chk(16'(statusOut.status0), 16'h0014);
    chk(16'(statusOut.status1), 16'h000F);
    chk(16'(statusOut.coldWarmStart), 16'h0001);
    // a supply dip is a second power-on: it alone may clear the cold/warm flag
    reset_source_model_i.supply(1'b1);
    cyc(3);
    reset_source_model_i.supply(1'b0);
    lowSpan(40, PH, PH + 2);
    chk(16'(statusOut.coldWarmStart), 16'h0000);
    chk(16'(statusOut.status0), 16'h0001 << ST0_POWERON_CAUSE_FLAG_BIT);
    chk(16'(statusOut.status1), 16'h0000);
    results();
  end
endmodule // reset_source_recorder_tb_top
`default_nettype wire
